//--- verilog/lmdc_defs.svh
// constants for the led mode and duty control block
`ifndef LMDC_DEFS_SVH
`define LMDC_DEFS_SVH
`define LMDC_ADDR_MODE_ONE 5'h00
`define LMDC_ADDR_MODE_TWO 5'h01
`define LMDC_ADDR_DUTY_FIRST 5'h02
`define LMDC_ADDR_DUTY_LAST 5'h09
`define LMDC_ADDR_GROUP_DUTY 5'h0a
`define LMDC_ADDR_STATE_LOW 5'h0c
`define LMDC_ADDR_STATE_HIGH 5'h0d
`define LMDC_ADDR_LAST 5'h11
`define LMDC_ADDR_GLOBAL_FIRST 5'h0a
`define LMDC_ADDR_GLOBAL_LAST 5'h0b
`define LMDC_MODE_ONE_RESET 8'h11
`define LMDC_MODE_TWO_RESET 8'h03
`define LMDC_MODE_ONE_WMASK 8'h1f
`define LMDC_MODE_TWO_WMASK 8'h2f
`define LMDC_BIT_SLEEP 4
`define LMDC_BIT_BLINK 5
`define LMDC_BIT_ON_ACK 3
`define LMDC_BIT_WDT_EN 2
`define LMDC_BIT_SECONDARY_ADDR_ONE_ENABLE 3
`define LMDC_BIT_SECONDARY_ADDR_TWO_ENABLE 2
`define LMDC_BIT_SECONDARY_ADDR_THREE_ENABLE 1
`define LMDC_BIT_BCAST 0
`define LMDC_CLOCK_HZ 200000000
`define LMDC_PWM_HZ 97000
`define LMDC_GROUP_HZ 190
`define LMDC_BLINK_HZ 24
// one pwm step lasts a 256th of the period; round down to stay at or above rate
`define LMDC_PWM_STEP_CYC ((`LMDC_CLOCK_HZ / `LMDC_PWM_HZ) / 256)
`define LMDC_GROUP_STEP_CYC ((`LMDC_CLOCK_HZ / `LMDC_GROUP_HZ) / 256)
// shortest blink step; the period register repeats it period + 1 times
`define LMDC_BLINK_STEP_CYC ((`LMDC_CLOCK_HZ / `LMDC_BLINK_HZ) / 256)
`endif

//--- verilog/lmdc_pkg.sv
// types for the led mode and duty control block
`default_nettype none
package lmdc_pkg;
  typedef enum logic [1:0] {
    LMDC_STATE_OFF = 2'b00,
    LMDC_STATE_ON = 2'b01,
    LMDC_STATE_INDIV = 2'b10,
    LMDC_STATE_GROUP = 2'b11
  } lmdc_out_state_type;
  typedef enum logic [2:0] {
    LMDC_AI_NONE = 3'b000,
    LMDC_AI_ALL = 3'b100,
    LMDC_AI_DUTY = 3'b101,
    LMDC_AI_GLOBAL = 3'b110,
    LMDC_AI_BOTH = 3'b111
  } lmdc_autoinc_type;
endpackage : lmdc_pkg
`default_nettype wire

//--- verilog/lmdc_core.sv
// mode registers, duty registers and pwm outputs of the eight channel led driver
//
// Contract
// - mode one bits 7:5 read-only, mirror control byte auto-increment bits, reset zero.
// - mode one bit 4 low-power, oscillator stopped; resets to one.
// - while oscillator stopped no output is switched, blinked or dimmed.
// - register writes are refused in low-power mode; the code still stores the mode one sleep bit.
// - mode one bits 3:1 enable secondary addresses one to three; reset zero.
// - mode one bit 0 enables broadcast address; resets to one.
// - mode two bit 5 chooses group dimming (0, reset) or blinking (1).
// - mode two bit 3: outputs update at stop (0) or each acknowledge (1).
// - update timing choice applies only to addresses 02h through 0dh.
// - mode two bits 7:6 and 4 read zero; bit 2 watchdog enable, reset zero.
// - eight read-write duty registers at 02h to 09h, reset zero.
// - each output has its own fixed 97 khz pwm.
// - duty equals value over 256; 00h off, ffh 99.6 percent.
// - individual duty acts only for state field 10 or 11.
// - state field 00 off, 01 on, 10 individual, 11 individual plus group.
// - group dimming superimposes 190 hz group duty on state 11 outputs.
// - with auto-increment set the pointer advances after each access, wrapping per option.

// overview of the block:
// - the protocol engine hands us one strobe per byte; we never see bus bits
// - the control byte sets the pointer and the auto-increment option
// - mode one and mode two live here, the group and state registers do not
// - duty bytes land in a shadow first and reach the pwm compare only at
//   the chosen update point, so several drivers can change together
// - one free running step counter serves all eight channels, which keeps
//   the channels in phase; a trade of area against spread switching noise
// - low-power mode freezes both timebases and the output flops
// - reset values of the two mode registers come from the defines header
`timescale 1ns/1ps
`default_nettype none
`include "lmdc_defs.svh"
module lmdc_core (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // register port from the bus protocol engine
  input wire logic i_ptr_load,
  input wire logic [7:0] i_ptr_byte,
  input wire logic i_wr_strobe,
  input wire logic [7:0] i_wr_data,
  input wire logic i_rd_strobe,
  input wire logic i_ack_event,
  input wire logic i_stop_event,
  // group control and output states from neighbouring registers
  input wire logic [7:0] i_group_duty_register,
  input wire logic [7:0] i_group_period_register,
  input wire logic [15:0] i_output_state_field,
  // register read data and pointer
  output logic [7:0] o_rd_data,
  output logic [4:0] o_ptr,
  output logic o_wr_refused,
  // address enables and mode
  output logic o_secondary_addr_one_enable,
  output logic o_secondary_addr_two_enable,
  output logic o_secondary_addr_three_enable,
  output logic o_broadcast_addr_enable,
  output logic o_osc_stopped,
  output logic o_group_blink_select,
  output logic o_watchdog_enable,
  output logic [1:0] o_watchdog_period_code,
  // led drive, high means led on
  output logic [7:0] o_led_on
);

  logic [2:0] autoinc_reg;
  logic [4:0] ptr_reg;
  logic [4:0] ptr_next;
  logic [7:0] mode_one_reg;
  logic [7:0] mode_two_reg;
  logic [7:0] shadow_reg [8];
  logic [7:0] active_reg [8];
  logic [7:0] shadow_dirty_reg;
  logic [7:0] rd_data_next;
  logic [7:0] pwm_step_reg;
  logic [7:0] pwm_cnt_reg;
  logic [15:0] grp_step_reg;
  logic [7:0] grp_cnt_reg;
  logic [7:0] led_reg;
  logic [7:0] rd_data_reg;
  logic refused_reg;
  logic sleeping;
  logic wr_ok;
  logic pwm_tick;
  logic grp_tick;
  logic group_gate;

  // address decode used by the write path and the read mux
  // duty registers sit in one contiguous run, so a subtraction gives the
  // channel index; callers must test is_duty first, as the index of an
  // address outside the run is meaningless
  function automatic logic is_duty(input logic [4:0] addr);
    is_duty = (addr >= `LMDC_ADDR_DUTY_FIRST) && (addr <= `LMDC_ADDR_DUTY_LAST);
  endfunction : is_duty

  function automatic logic [2:0] duty_index(input logic [4:0] addr);
    logic [4:0] diff;
    diff = addr - `LMDC_ADDR_DUTY_FIRST;
    duty_index = diff[2:0];
  endfunction : duty_index

  assign sleeping = mode_one_reg[`LMDC_BIT_SLEEP];
  assign wr_ok = i_wr_strobe && !sleeping;

  // pointer advance; pointer loads from the control byte
  // each option wraps at its own last register; a pointer already past
  // that register also wraps, so a start point beyond the range cannot
  // run off into unused addresses
  // reserved option codes are held still rather than guessed at
  always_comb begin
    ptr_next = ptr_reg;
    if (autoinc_reg[2]) begin
      unique case (lmdc_pkg::lmdc_autoinc_type'(autoinc_reg))
        lmdc_pkg::LMDC_AI_ALL:
          ptr_next = (ptr_reg >= `LMDC_ADDR_LAST) ? `LMDC_ADDR_MODE_ONE : ptr_reg + 5'h01;
        lmdc_pkg::LMDC_AI_DUTY:
          ptr_next = (ptr_reg >= `LMDC_ADDR_DUTY_LAST) ? `LMDC_ADDR_DUTY_FIRST : ptr_reg + 5'h01;
        lmdc_pkg::LMDC_AI_GLOBAL:
          ptr_next = (ptr_reg >= `LMDC_ADDR_GLOBAL_LAST) ? `LMDC_ADDR_GLOBAL_FIRST : ptr_reg + 5'h01;
        lmdc_pkg::LMDC_AI_BOTH:
          ptr_next = (ptr_reg >= `LMDC_ADDR_GLOBAL_LAST) ? `LMDC_ADDR_DUTY_FIRST : ptr_reg + 5'h01;
        default:
          ptr_next = ptr_reg; // reserved options hold the pointer
      endcase
    end
  end

  // control byte: pointer and auto-increment bits
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      autoinc_reg <= 3'h0;
      ptr_reg <= 5'h00;
    end else if (i_ptr_load) begin
      autoinc_reg <= i_ptr_byte[7:5];
      ptr_reg <= i_ptr_byte[4:0];
    end else if (i_wr_strobe || i_rd_strobe) begin
      ptr_reg <= ptr_next; // refused writes still advance, as the bus sees a byte taken
    end
  end

  // mode register one; sleep itself stays writable so the master can wake us
  // auto-increment bits are not stored here: reads splice in the live
  // control byte bits, so the two can never disagree
  // while asleep every other bit keeps its value, even on a full byte write
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      mode_one_reg <= `LMDC_MODE_ONE_RESET;
    end else if (i_wr_strobe && ptr_reg == `LMDC_ADDR_MODE_ONE) begin
      if (sleeping) begin
        mode_one_reg[`LMDC_BIT_SLEEP] <= i_wr_data[`LMDC_BIT_SLEEP];
      end else begin
        mode_one_reg <= i_wr_data & `LMDC_MODE_ONE_WMASK;
      end
    end
  end

  // mode register two; reserved bits never store
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      mode_two_reg <= `LMDC_MODE_TWO_RESET;
    end else if (wr_ok && ptr_reg == `LMDC_ADDR_MODE_TWO) begin
      mode_two_reg <= i_wr_data & `LMDC_MODE_TWO_WMASK;
    end
  end

  // duty shadows and active compares, one per channel
  // the dirty flag marks a shadow that has not reached its compare yet;
  // a commit with nothing pending leaves the compare untouched
  // ack mode commits on every acknowledge, so a byte takes effect right
  // after it is acknowledged; stop mode waits for the end of the transfer
  // limitation: output state bytes are committed by their own block
  genvar ch;
  generate
    for (ch = 0; ch < 8; ch = ch + 1) begin : g_duty
      logic hit;
      logic commit;
      assign hit = wr_ok && is_duty(ptr_reg) && (duty_index(ptr_reg) == 3'(ch));
      // stop commits everything pending; ack commits per byte when selected
      assign commit = mode_two_reg[`LMDC_BIT_ON_ACK] ? i_ack_event : i_stop_event;

      always_ff @(posedge i_clock) begin
        if (i_srst) begin
          shadow_reg[ch] <= 8'h00;
          shadow_dirty_reg[ch] <= 1'b0;
        end else if (hit) begin
          shadow_reg[ch] <= i_wr_data;
          shadow_dirty_reg[ch] <= 1'b1;
        end else if (commit) begin
          shadow_dirty_reg[ch] <= 1'b0;
        end
      end

      // write and commit in one cycle still takes the new byte
      always_ff @(posedge i_clock) begin
        if (i_srst) begin
          active_reg[ch] <= 8'h00;
        end else if (commit && hit) begin
          active_reg[ch] <= i_wr_data;
        end else if (commit && shadow_dirty_reg[ch]) begin
          active_reg[ch] <= shadow_reg[ch];
        end
      end
    end
  endgenerate

  // read mux; reads return the shadow so software sees what it wrote
  // addresses owned by other blocks read zero here and are merged outside
  always_comb begin
    rd_data_next = 8'h00;
    if (ptr_reg == `LMDC_ADDR_MODE_ONE) begin
      rd_data_next = {autoinc_reg, mode_one_reg[4:0]};
    end else if (ptr_reg == `LMDC_ADDR_MODE_TWO) begin
      rd_data_next = mode_two_reg;
    end else if (is_duty(ptr_reg)) begin
      rd_data_next = shadow_reg[duty_index(ptr_reg)];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      rd_data_reg <= 8'h00;
      refused_reg <= 1'b0;
    end else begin
      rd_data_reg <= rd_data_next;
      refused_reg <= i_wr_strobe && sleeping;
    end
  end

  // 97 khz pwm timebase; frozen while the oscillator is stopped
  // the step length is rounded down, so the real rate sits a little above
  // nominal; rounding up would have dropped below it instead
  // counters restart from zero on wake, so the first period after sleep is
  // a full one and no short pulse appears
  always_ff @(posedge i_clock) begin
    if (i_srst || sleeping) begin
      pwm_step_reg <= 8'h00;
      pwm_cnt_reg <= 8'h00;
    end else if (pwm_tick) begin
      pwm_step_reg <= 8'h00;
      pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
    end else begin
      pwm_step_reg <= pwm_step_reg + 8'h01;
    end
  end
  assign pwm_tick = (pwm_step_reg == 8'(`LMDC_PWM_STEP_CYC - 1));

  // group timebase: 190 hz for dimming, (period + 1) / 24 s for blinking
  // a blink step is the 24 hz step repeated period + 1 times, so the step
  // counter stays 16 bits wide even at the slowest blink rate
  // end test is at-or-above: switching from blink to dim mid-step would
  // otherwise leave the counter to run all the way round
  logic grp_step_end;
  logic [7:0] blink_rep_reg;
  assign grp_step_end = mode_two_reg[`LMDC_BIT_BLINK]
    ? (grp_step_reg >= 16'(`LMDC_BLINK_STEP_CYC - 1))
    : (grp_step_reg >= 16'(`LMDC_GROUP_STEP_CYC - 1));
  assign grp_tick = grp_step_end && (!mode_two_reg[`LMDC_BIT_BLINK] || blink_rep_reg >= i_group_period_register);

  always_ff @(posedge i_clock) begin
    if (i_srst || sleeping) begin
      grp_step_reg <= 16'h0000;
      grp_cnt_reg <= 8'h00;
      blink_rep_reg <= 8'h00;
    end else if (grp_tick) begin
      grp_step_reg <= 16'h0000;
      grp_cnt_reg <= grp_cnt_reg + 8'h01;
      blink_rep_reg <= 8'h00;
    end else if (grp_step_end) begin
      grp_step_reg <= 16'h0000;
      blink_rep_reg <= blink_rep_reg + 8'h01;
    end else begin
      grp_step_reg <= grp_step_reg + 16'h0001;
    end
  end
  assign group_gate = grp_cnt_reg < i_group_duty_register;

  // output select per channel; outputs hold their level while asleep
  // the state field is read live, so a state change shows one cycle later
  // group gating multiplies the two pwm signals; in blink mode the same
  // gate gives the on and off phases of the blink
  generate
    for (ch = 0; ch < 8; ch = ch + 1) begin : g_out
      logic indiv;
      assign indiv = pwm_cnt_reg < active_reg[ch];
      always_ff @(posedge i_clock) begin
        if (i_srst) begin
          led_reg[ch] <= 1'b0;
        end else if (!sleeping) begin
          unique case (lmdc_pkg::lmdc_out_state_type'(i_output_state_field[2*ch +: 2]))
            lmdc_pkg::LMDC_STATE_OFF: led_reg[ch] <= 1'b0;
            lmdc_pkg::LMDC_STATE_ON: led_reg[ch] <= 1'b1;
            lmdc_pkg::LMDC_STATE_INDIV: led_reg[ch] <= indiv;
            lmdc_pkg::LMDC_STATE_GROUP: led_reg[ch] <= indiv && group_gate;
          endcase
        end
      end
    end
  endgenerate

  // outputs straight from flip-flops
  // address enables feed the protocol engine's address match; the sleep
  // flag also tells the engine to hold off anything but a wake write
  assign o_rd_data = rd_data_reg;
  assign o_ptr = ptr_reg;
  assign o_wr_refused = refused_reg;
  assign o_secondary_addr_one_enable = mode_one_reg[`LMDC_BIT_SECONDARY_ADDR_ONE_ENABLE];
  assign o_secondary_addr_two_enable = mode_one_reg[`LMDC_BIT_SECONDARY_ADDR_TWO_ENABLE];
  assign o_secondary_addr_three_enable = mode_one_reg[`LMDC_BIT_SECONDARY_ADDR_THREE_ENABLE];
  assign o_broadcast_addr_enable = mode_one_reg[`LMDC_BIT_BCAST];
  assign o_osc_stopped = mode_one_reg[`LMDC_BIT_SLEEP];
  assign o_group_blink_select = mode_two_reg[`LMDC_BIT_BLINK];
  assign o_watchdog_enable = mode_two_reg[`LMDC_BIT_WDT_EN];
  assign o_watchdog_period_code = mode_two_reg[1:0];
  assign o_led_on = led_reg;

endmodule : lmdc_core
`default_nettype wire

//--- dv/lmdc_monitor.sv
// checker for the led mode and duty control block
`timescale 1ns/1ps
`default_nettype none
module lmdc_monitor (
  // clock, reset and requests
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_ptr_load,
  input wire logic [7:0] i_ptr_byte,
  input wire logic i_wr_strobe,
  input wire logic i_rd_strobe,
  input wire logic [15:0] i_output_state_field,
  // watched outputs
  input wire logic [7:0] o_rd_data,
  input wire logic [4:0] o_ptr,
  input wire logic o_wr_refused,
  input wire logic o_osc_stopped,
  input wire logic o_broadcast_addr_enable,
  input wire logic [1:0] o_watchdog_period_code,
  input wire logic [7:0] o_led_on
);
  logic [2:0] ai_reg;
  logic [1:0] calm_reg;
  logic [7:0] off_mask;
  // autoinc bits of the last control byte
  always_ff @(posedge i_clock) begin
    if (i_srst) ai_reg <= 3'h0;
    else if (i_ptr_load) ai_reg <= i_ptr_byte[7:5];
  end
  // cycles the state field stood still; leds lag a field change
  always_ff @(posedge i_clock) begin
    if (i_srst || $changed(i_output_state_field)) calm_reg <= 2'h0;
    else if (calm_reg != 2'h3) calm_reg <= calm_reg + 2'h1;
  end
  // leds whose field says off
  always_comb begin
    for (int n = 0; n < 8; n++) off_mask[n] = i_output_state_field[2*n +: 2] == 2'b00;
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_srst);
  a_reset_values: assert property ($fell(i_srst) |-> o_osc_stopped && o_broadcast_addr_enable
    && o_watchdog_period_code == 2'h3 && o_led_on == 8'h00) else $error("bad reset values");
  a_refuse_asleep: assert property (i_wr_strobe && o_osc_stopped && o_ptr != 5'h00 |=> o_wr_refused)
    else $error("sleep write taken");
  a_sleep_freeze: assert property (o_osc_stopped && $past(o_osc_stopped) |-> $stable(o_led_on))
    else $error("leds moved asleep");
  a_off_dark: assert property (calm_reg == 2'h3 && !o_osc_stopped && !$past(o_osc_stopped, 2)
    |-> (o_led_on & off_mask) == 8'h00) else $error("off led lit");
  a_mode_mirror: assert property (o_ptr == 5'h00 && $past(o_ptr) == 5'h00 && !$past(i_ptr_load)
    |-> o_rd_data[7:5] == ai_reg) else $error("autoinc bits wrong");
  a_mode_rsvd: assert property (o_ptr == 5'h01 && $past(o_ptr) == 5'h01 |-> (o_rd_data & 8'hd0) == 8'h00)
    else $error("reserved bits set");
  a_ptr_hold: assert property ((i_wr_strobe || i_rd_strobe) && !i_ptr_load && !ai_reg[2] |=> $stable(o_ptr))
    else $error("pointer moved");
  a_duty_wrap: assert property ((i_wr_strobe || i_rd_strobe) && !i_ptr_load && ai_reg == 3'b101
    && o_ptr == 5'h09 |=> o_ptr == 5'h02) else $error("duty wrap wrong");
  c_refused: cover property (o_wr_refused);
  c_lit: cover property ($rose(o_led_on[0]));
  c_wrap: cover property (o_ptr == 5'h02 && $past(o_ptr) == 5'h09);
endmodule : lmdc_monitor
bind lmdc_core lmdc_monitor u_monitor (.*);
`default_nettype wire

//--- dv/lmdc_bus_master.sv
// bus master model issuing register port requests
`timescale 1ns/1ps
`default_nettype none
module lmdc_bus_master #(
  parameter int WAKE_WAIT_CYC = 200
) (
  // clock
  input wire logic i_clock,
  // requests toward the block, events as read, ack, stop
  output var logic o_ptr_load = 1'b0,
  output var logic [7:0] o_ptr_byte = 8'h00,
  output var logic o_wr_strobe = 1'b0,
  output var logic [7:0] o_wr_data = 8'h00,
  output var logic [2:0] o_events = 3'h0
);
  // byte lines scrambled once released so stale data cannot pass
  task automatic set_ptr(input logic [7:0] b);
    @(posedge i_clock);
    o_ptr_load <= 1'b1;
    o_ptr_byte <= b;
    @(posedge i_clock);
    o_ptr_load <= 1'b0;
    o_ptr_byte <= ~b;
  endtask : set_ptr
  task automatic write(input logic [7:0] d);
    @(posedge i_clock);
    o_wr_strobe <= 1'b1;
    o_wr_data <= d;
    @(posedge i_clock);
    o_wr_strobe <= 1'b0;
    o_wr_data <= ~d;
  endtask : write
  task automatic pulse(input logic [2:0] sel);
    @(posedge i_clock);
    o_events <= sel;
    @(posedge i_clock);
    o_events <= 3'h0;
  endtask : pulse
  // oscillator restart pause, shortened to keep runs brief
  task automatic wake_wait;
    repeat (WAKE_WAIT_CYC) @(posedge i_clock);
  endtask : wake_wait
endmodule : lmdc_bus_master
`default_nettype wire

//--- dv/test_led_mode_and_duty_control.sv
// self-checking testbench for the led mode and duty control block
`timescale 1ns/1ps
`default_nettype none
`include "lmdc_defs.svh"
module test_led_mode_and_duty_control;
  localparam int S = `LMDC_PWM_STEP_CYC;
  localparam int P = S * 256;
  logic i_clock = 1'b0;
  logic i_srst = 1'b1;
  logic i_ptr_load, i_wr_strobe, i_rd_strobe, i_ack_event, i_stop_event, o_wr_refused, o_osc_stopped;
  logic o_secondary_addr_one_enable, o_secondary_addr_two_enable, o_secondary_addr_three_enable;
  logic o_broadcast_addr_enable, o_group_blink_select, o_watchdog_enable;
  logic [7:0] i_ptr_byte, i_wr_data, o_rd_data, o_led_on;
  logic [7:0] i_group_duty_register = 8'hff;
  logic [7:0] i_group_period_register = 8'h00;
  logic [15:0] i_output_state_field = 16'h0000;
  logic [4:0] o_ptr;
  logic [1:0] o_watchdog_period_code;
  logic [2:0] ev;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  // master model and block
  assign {i_rd_strobe, i_ack_event, i_stop_event} = ev;
  lmdc_bus_master u_master (.i_clock, .o_ptr_load(i_ptr_load), .o_ptr_byte(i_ptr_byte), .o_wr_strobe(i_wr_strobe),
    .o_wr_data(i_wr_data), .o_events(ev));
  lmdc_core u_dut (.*);
  // clock and hang guard
  initial forever #2.5 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      finish_test();
    end
  end
  task automatic finish_test;
    if (errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      errors++;
    end
  endtask : check8
  task automatic checkn(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      $display("wrong value at %0t: led count %0d expected %0d", $time, got, exp);
      errors++;
    end
  endtask : checkn
  task automatic read_reg(input logic [7:0] ctl, output logic [7:0] v);
    u_master.set_ptr(ctl);
    @(posedge i_clock);
    #1 v = o_rd_data;
  endtask : read_reg
  // high cycles per led over one full period; phase does not matter
  task automatic measure(input int e [8]);
    int c [8] = '{default: 0};
    repeat (4) @(posedge i_clock);
    repeat (P) begin
      @(posedge i_clock);
      #1;
      for (int n = 0; n < 8; n++) c[n] += int'(o_led_on[n] === 1'b1);
    end
    for (int n = 0; n < 8; n++) checkn(c[n], e[n]);
  endtask : measure
  task automatic t_reset_sleep;
    logic [7:0] v;
    read_reg(8'h00, v);
    check8(v, 8'h11);
    read_reg(8'h01, v);
    check8(v, 8'h03);
    for (int a = 2; a < 10; a++) begin
      read_reg(8'(a), v);
      check8(v, 8'h00);
    end
    u_master.write(8'h55);
    read_reg(8'h09, v);
    check8(v, 8'h00);
    u_master.set_ptr(8'h00);
    u_master.write(8'h00);
    read_reg(8'h00, v);
    check8(v, 8'h01);
    u_master.wake_wait();
  endtask : t_reset_sleep
  task automatic t_mode;
    logic [7:0] v;
    u_master.set_ptr(8'h80);
    u_master.write(8'h0e);
    u_master.write(8'hff);
    read_reg(8'h80, v);
    check8(v, 8'h8e);
    check8({4'h0, o_secondary_addr_one_enable, o_secondary_addr_two_enable, o_secondary_addr_three_enable,
      o_broadcast_addr_enable}, 8'h0e);
    read_reg(8'h01, v);
    check8(v, 8'h2f);
    check8({4'h0, o_group_blink_select, o_watchdog_enable, o_watchdog_period_code}, 8'h0f);
    u_master.write(8'h00);
    #1 check8({4'h0, o_group_blink_select, o_watchdog_enable, o_watchdog_period_code}, 8'h00);
  endtask : t_mode
  task automatic t_wrap;
    logic [7:0] ctl [5] = '{8'ha9, 8'hcb, 8'h91, 8'heb, 8'h04};
    logic [7:0] exp [5] = '{8'h02, 8'h0a, 8'h00, 8'h02, 8'h04};
    for (int i = 0; i < 5; i++) begin
      u_master.set_ptr(ctl[i]);
      u_master.pulse(3'b100);
      #1 check8({3'h0, o_ptr}, exp[i]);
    end
  endtask : t_wrap
  task automatic t_pwm;
    int e [8] = '{0, 0, P, 0, 0, 0, 0, 0};
    @(posedge i_clock);
    i_output_state_field <= 16'h021a;
    u_master.set_ptr(8'ha2);
    u_master.write(8'h80);
    u_master.write(8'hff);
    u_master.write(8'h40);
    u_master.write(8'hff);
    u_master.write(8'h00);
    measure(e);
    u_master.pulse(3'b001);
    e = '{128 * S, 255 * S, P, 0, 0, 0, 0, 0};
    measure(e);
    u_master.set_ptr(8'h01);
    u_master.write(8'h08);
    u_master.set_ptr(8'h02);
    u_master.write(8'h10);
    u_master.pulse(3'b010);
    e[0] = 16 * S;
    measure(e);
    // led1 under group control, gate at full then at zero duty
    @(posedge i_clock);
    i_output_state_field <= 16'h021e;
    i_group_period_register <= 8'h01;
    measure(e);
    @(posedge i_clock);
    i_group_duty_register <= 8'h00;
    e[1] = 0;
    measure(e);
    u_master.set_ptr(8'h00);
    u_master.write(8'h10);
    #1 check8({7'h0, o_osc_stopped}, 8'h01);
    repeat (300) @(posedge i_clock);
  endtask : t_pwm
  // reset, then the scenarios in turn
  initial begin
    repeat (10) @(posedge i_clock);
    i_srst <= 1'b0;
    t_reset_sleep();
    t_mode();
    t_wrap();
    t_pwm();
    finish_test();
  end
endmodule : test_led_mode_and_duty_control
`default_nettype wire
